// [logic/cfe_pkg.sv]
package cfe_pkg;

    ////////////////////////////////////////////////////////////
    // Condition codes
    localparam logic [3:0] COND_EQUAL = 4'h0;
    localparam logic [3:0] COND_NOT_EQUAL = 4'h1;
    localparam logic [3:0] COND_UNSIGNED_HIGHER_SAME = 4'h2;
    localparam logic [3:0] COND_UNSIGNED_LOWER = 4'h3;
    localparam logic [3:0] COND_NEGATIVE = 4'h4;
    localparam logic [3:0] COND_POSITIVE_OR_ZERO = 4'h5;
    localparam logic [3:0] COND_OVERFLOW_SET = 4'h6;
    localparam logic [3:0] COND_OVERFLOW_CLEAR = 4'h7;
    localparam logic [3:0] COND_UNSIGNED_HIGHER = 4'h8;
    localparam logic [3:0] COND_UNSIGNED_LOWER_SAME = 4'h9;
    localparam logic [3:0] COND_SIGNED_GREATER_EQUAL = 4'hA;
    localparam logic [3:0] COND_SIGNED_LESS = 4'hB;
    localparam logic [3:0] COND_SIGNED_GREATER = 4'hC;
    localparam logic [3:0] COND_SIGNED_LESS_EQUAL = 4'hD;
    localparam logic [3:0] COND_ALWAYS = 4'hE;

    ////////////////////////////////////////////////////////////
    // Operation classes
    localparam logic [2:0] OP_ADD = 3'h0;
    localparam logic [2:0] OP_SUB = 3'h1;
    localparam logic [2:0] OP_MOVE = 3'h2;
    localparam logic [2:0] OP_AND = 3'h3;
    localparam logic [2:0] OP_OR = 3'h4;
    localparam logic [2:0] OP_XOR = 3'h5;
    localparam logic [2:0] OP_LOAD_ADDR = 3'h6;
    localparam logic [2:0] OP_NONE = 3'h7;

    ////////////////////////////////////////////////////////////
    // Program counter base
    localparam logic [31:0] PC_AHEAD = 32'h0000_0004;
    localparam int PC_ALIGN_BIT = 1;

    ////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [31:0] RESULT_RESET = 32'h0000_0000;
    localparam logic [3:0] FLAGS_RESET = 4'h0;

endpackage : cfe_pkg

// [logic/cfe_condition_flag_evaluator.sv]
`timescale 1ns/1ns

// Notes on behaviour
// RULE_01: Branch label base is address plus four.
// RULE_02: Other label bases: plus four, bit1 cleared.
// RULE_03: Flags not updated keep previous value.
// RULE_04: Failed condition: no write, flags, exception.
// RULE_05: Conditional non-branch needs if-then block.
// RULE_06: Sign flag follows result bit 31.
// RULE_07: Zero flag set when result zero.
// RULE_08: Addition carry out of bit 31.
// RULE_09: Subtraction carry means no borrow.
// RULE_10: Move and logical take shifter carry.
// RULE_11: Add or subtract signed overflow sets flag.
// RULE_12: Flags written only with set-flags bit.
// RULE_13: Equal, negative, overflow tests and inverses.
// RULE_14: Carry set and carry clear tests.
// RULE_15: Unsigned higher and lower-or-same tests.
// RULE_16: Signed greater-equal and less tests.
// RULE_17: Signed greater: zero clear, sign equals overflow.
// RULE_18: Always passes; no suffix means always.
// RULE_19: Both encoding widths execute identically.
// RULE_20: Load address adds offset to base.
// RULE_21: Signed less-or-equal complements greater.
// RULE_22: Next instruction sees new flags, no stall.
module cfe_condition_flag_evaluator (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic clk_en,
    input wire logic instr_valid,
    input wire logic [31:0] instr_addr,
    input wire logic instr_wide,
    input wire logic [3:0] cond_code,
    input wire logic in_if_then_block,
    input wire logic is_label_branch,
    input wire logic [2:0] op_class,
    input wire logic set_flags,
    input wire logic dest_write,
    input wire logic exc_request,
    input wire logic [31:0] operand_a,
    input wire logic [31:0] operand_b,
    input wire logic shift_carry,
    input wire logic shift_carry_valid,
    input wire logic [31:0] label_offset,
    output logic msb_flag,
    output logic all_clear_flag,
    output logic unsigned_wrap_bit,
    output logic signed_wrap_bit,
    output logic [31:0] result_data,
    output logic result_write,
    output logic exec_taken,
    output logic exc_raised,
    output logic [31:0] pc_base,
    output logic result_wide,
    output logic cond_misplaced
);

    ////////////////////////////////////////////////////////////
    // Condition test against current flags
    function automatic logic cond_pass(
        input logic [3:0] cc,
        input logic n,
        input logic z,
        input logic c,
        input logic v
    );
        logic p;
        p = 1'b1;
        case (cc)
            cfe_pkg::COND_EQUAL: p = z; // see RULE_13
            cfe_pkg::COND_NOT_EQUAL: p = !z;
            cfe_pkg::COND_UNSIGNED_HIGHER_SAME: p = c; // see RULE_14
            cfe_pkg::COND_UNSIGNED_LOWER: p = !c;
            cfe_pkg::COND_NEGATIVE: p = n;
            cfe_pkg::COND_POSITIVE_OR_ZERO: p = !n;
            cfe_pkg::COND_OVERFLOW_SET: p = v;
            cfe_pkg::COND_OVERFLOW_CLEAR: p = !v;
            cfe_pkg::COND_UNSIGNED_HIGHER: p = c && !z; // see RULE_15
            cfe_pkg::COND_UNSIGNED_LOWER_SAME: p = !c || z;
            cfe_pkg::COND_SIGNED_GREATER_EQUAL: p = (n == v); // see RULE_16
            cfe_pkg::COND_SIGNED_LESS: p = (n != v);
            cfe_pkg::COND_SIGNED_GREATER: p = !z && (n == v); // see RULE_17
            cfe_pkg::COND_SIGNED_LESS_EQUAL: p = z || (n != v); // see RULE_21
            default: p = 1'b1; // see RULE_18
        endcase
        return p;
    endfunction : cond_pass

    ////////////////////////////////////////////////////////////
    // Decode and gating
    wire logic cond_ok;
    wire logic is_always;
    wire logic placement_ok;
    wire logic do_exec;
    wire logic is_arith;
    wire logic is_logic;
    wire logic flag_upd;

    assign cond_ok = cond_pass(cond_code, msb_flag, all_clear_flag,
                               unsigned_wrap_bit, signed_wrap_bit);
    assign is_always = (cond_code == cfe_pkg::COND_ALWAYS);
    // Only branches may be conditional outside an if-then block
    assign placement_ok = is_always || is_label_branch || in_if_then_block; // see RULE_05
    assign do_exec = instr_valid && placement_ok && cond_ok; // see RULE_04
    assign is_arith = (op_class == cfe_pkg::OP_ADD) || (op_class == cfe_pkg::OP_SUB);
    assign is_logic = (op_class == cfe_pkg::OP_MOVE) || (op_class == cfe_pkg::OP_AND)
                   || (op_class == cfe_pkg::OP_OR) || (op_class == cfe_pkg::OP_XOR);
    // Flags change only when asked and the instruction runs
    assign flag_upd = do_exec && set_flags && (is_arith || is_logic); // see RULE_12

    ////////////////////////////////////////////////////////////
    // Adder; subtraction is a plus inverted b plus one
    wire logic is_sub;
    wire logic [31:0] add_b;
    wire logic [32:0] sum33;
    wire logic add_ovf;

    assign is_sub = (op_class == cfe_pkg::OP_SUB);
    assign add_b = is_sub ? ~operand_b : operand_b;
    assign sum33 = {1'b0, operand_a} + {1'b0, add_b} + {32'h0000_0000, is_sub};
    // Same operand signs, result sign differs
    assign add_ovf = (operand_a[31] == add_b[31]) && (sum33[31] != operand_a[31]); // see RULE_11

    ////////////////////////////////////////////////////////////
    // Program counter base for label operands
    wire logic [31:0] pc_ahead;
    wire logic [31:0] pc_word;
    wire logic [31:0] next_pc_base;
    wire logic [31:0] adr_sum;

    // Width of the encoding does not move the base
    assign pc_ahead = instr_addr + cfe_pkg::PC_AHEAD; // see RULE_01
    assign pc_word = pc_ahead & ~(32'h0000_0001 << cfe_pkg::PC_ALIGN_BIT); // see RULE_02
    assign next_pc_base = is_label_branch ? pc_ahead : pc_word;
    assign adr_sum = pc_word + label_offset; // see RULE_20

    ////////////////////////////////////////////////////////////
    // Result selection
    logic [31:0] next_res;

    always_comb begin
        next_res = cfe_pkg::RESULT_RESET;
        case (op_class)
            cfe_pkg::OP_ADD: next_res = sum33[31:0];
            cfe_pkg::OP_SUB: next_res = sum33[31:0];
            cfe_pkg::OP_MOVE: next_res = operand_b;
            cfe_pkg::OP_AND: next_res = operand_a & operand_b;
            cfe_pkg::OP_OR: next_res = operand_a | operand_b;
            cfe_pkg::OP_XOR: next_res = operand_a ^ operand_b;
            cfe_pkg::OP_LOAD_ADDR: next_res = adr_sum; // see RULE_20
            default: next_res = operand_a;
        endcase
    end

    ////////////////////////////////////////////////////////////
    // Next flag values
    wire logic next_n;
    wire logic next_z;
    wire logic next_c;
    wire logic next_v;
    wire logic logic_c;

    assign next_n = flag_upd ? next_res[31] : msb_flag; // see RULE_06
    assign next_z = flag_upd ? (next_res == 32'h0000_0000) : all_clear_flag; // see RULE_07
    // Carry out of bit 31; for subtract that is no-borrow
    assign logic_c = shift_carry_valid ? shift_carry : unsigned_wrap_bit; // see RULE_10
    assign next_c = !flag_upd ? unsigned_wrap_bit
                  : is_arith ? sum33[32] : logic_c; // see RULE_08 see RULE_09
    // Logical ops leave overflow alone
    assign next_v = (flag_upd && is_arith) ? add_ovf : signed_wrap_bit; // see RULE_03

    ////////////////////////////////////////////////////////////
    // Flag register; read directly by the next cycle's test
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            {msb_flag, all_clear_flag, unsigned_wrap_bit, signed_wrap_bit} <= cfe_pkg::FLAGS_RESET;
        end else if (clk_en) begin
            {msb_flag, all_clear_flag, unsigned_wrap_bit, signed_wrap_bit}
                <= {next_n, next_z, next_c, next_v}; // see RULE_22
        end
    end

    ////////////////////////////////////////////////////////////
    // Registered result outputs
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            result_data <= cfe_pkg::RESULT_RESET;
            result_write <= 1'b0;
            exec_taken <= 1'b0;
            exc_raised <= 1'b0;
            pc_base <= cfe_pkg::RESULT_RESET;
            result_wide <= 1'b0;
            cond_misplaced <= 1'b0;
        end else if (clk_en) begin
            result_data <= next_res;
            result_write <= do_exec && dest_write; // see RULE_04
            exec_taken <= do_exec;
            exc_raised <= do_exec && exc_request; // see RULE_04
            pc_base <= next_pc_base;
            result_wide <= instr_wide; // see RULE_19
            cond_misplaced <= instr_valid && !placement_ok;
        end
    end

    ////////////////////////////////////////////////////////////
    // Sign-extended sums, read only by the checks below
    wire logic [32:0] chk_sadd;
    wire logic [32:0] chk_ssub;

    assign chk_sadd = {operand_a[31], operand_a} + {operand_b[31], operand_b};
    assign chk_ssub = {operand_a[31], operand_a} - {operand_b[31], operand_b};

    ////////////////////////////////////////////////////////////
    // Checks
    AST_PC_BRANCH: assert property (@(posedge mclk) disable iff (!resetn) // see RULE_01
        clk_en && instr_valid && is_label_branch
        |=> pc_base == $past(instr_addr) + cfe_pkg::PC_AHEAD)
        else $error("branch base not address plus four");

    AST_PC_WORD: assert property (@(posedge mclk) disable iff (!resetn) // see RULE_02
        clk_en && instr_valid && !is_label_branch
        |=> !pc_base[1] && (pc_base[31:2] == $past(pc_ahead[31:2])))
        else $error("label base not word aligned");

    AST_FLAGS_HELD: assert property (@(posedge mclk) disable iff (!resetn) // see RULE_03
        !(clk_en && flag_upd)
        |=> $stable({msb_flag, all_clear_flag, unsigned_wrap_bit, signed_wrap_bit}))
        else $error("flags moved without update");

    AST_FAIL_QUIET: assert property (@(posedge mclk) disable iff (!resetn) // see RULE_04
        clk_en && instr_valid && !cond_ok
        |=> !result_write && !exc_raised && !exec_taken
            && $stable({msb_flag, all_clear_flag, unsigned_wrap_bit, signed_wrap_bit}))
        else $error("failed condition had an effect");

    AST_OUTSIDE_BLOCK: assert property (@(posedge mclk) disable iff (!resetn) // see RULE_05
        clk_en && instr_valid && !is_always && !is_label_branch && !in_if_then_block
        |=> !exec_taken && cond_misplaced)
        else $error("conditional ran outside block");

    AST_NZ: assert property (@(posedge mclk) disable iff (!resetn) // see RULE_07
        clk_en && flag_upd
        |=> msb_flag == result_data[31] && all_clear_flag == (result_data == 32'h0000_0000))
        else $error("sign or zero flag wrong");

    AST_ADD_CARRY: assert property (@(posedge mclk) disable iff (!resetn) // see RULE_08
        clk_en && flag_upd && op_class == cfe_pkg::OP_ADD
        |=> unsigned_wrap_bit == (({1'b0, $past(operand_a)} + {1'b0, $past(operand_b)}) >> 32))
        else $error("add carry wrong");

    AST_SUB_BORROW: assert property (@(posedge mclk) disable iff (!resetn) // see RULE_09
        clk_en && flag_upd && is_sub
        |=> unsigned_wrap_bit == ($past(operand_a) >= $past(operand_b)))
        else $error("subtract carry wrong");

    AST_LOGIC_CARRY: assert property (@(posedge mclk) disable iff (!resetn) // see RULE_10
        clk_en && flag_upd && is_logic && shift_carry_valid
        |=> unsigned_wrap_bit == $past(shift_carry) && $stable(signed_wrap_bit))
        else $error("logical carry wrong");

    AST_GREATER: assert property (@(posedge mclk) disable iff (!resetn) // see RULE_17
        clk_en && instr_valid && in_if_then_block
        && cond_code == cfe_pkg::COND_SIGNED_GREATER
        |=> exec_taken == $past(!all_clear_flag && (msb_flag == signed_wrap_bit)))
        else $error("greater test wrong");

    AST_LESS_EQUAL: assert property (@(posedge mclk) disable iff (!resetn) // see RULE_21
        clk_en && instr_valid && in_if_then_block
        && cond_code == cfe_pkg::COND_SIGNED_LESS_EQUAL
        |=> exec_taken == $past(all_clear_flag || (msb_flag != signed_wrap_bit)))
        else $error("less-or-equal test wrong");

    AST_ALWAYS: assert property (@(posedge mclk) disable iff (!resetn) // see RULE_18
        clk_en && instr_valid && is_always
        |=> exec_taken ##1 1'b1)
        else $error("always did not execute");

    AST_ADR: assert property (@(posedge mclk) disable iff (!resetn) // see RULE_20
        clk_en && do_exec && op_class == cfe_pkg::OP_LOAD_ADDR
        |=> result_data == $past(pc_word) + $past(label_offset)
            && $stable({msb_flag, all_clear_flag, unsigned_wrap_bit, signed_wrap_bit}))
        else $error("load address wrong");

    AST_ADD_SIGN: assert property (@(posedge mclk) disable iff (!resetn) // see RULE_06
        clk_en && flag_upd && op_class == cfe_pkg::OP_ADD
        |=> msb_flag == $past(chk_sadd[31]))
        else $error("add sign flag wrong");

    AST_ADD_OVF: assert property (@(posedge mclk) disable iff (!resetn) // see RULE_11
        clk_en && flag_upd && op_class == cfe_pkg::OP_ADD
        |=> signed_wrap_bit == $past(chk_sadd[32] != chk_sadd[31]))
        else $error("add overflow flag wrong");

    AST_SUB_OVF: assert property (@(posedge mclk) disable iff (!resetn) // see RULE_11
        clk_en && flag_upd && is_sub
        |=> signed_wrap_bit == $past(chk_ssub[32] != chk_ssub[31]))
        else $error("subtract overflow flag wrong");

    AST_NO_SUFFIX: assert property (@(posedge mclk) disable iff (!resetn) // see RULE_12
        clk_en && instr_valid && !set_flags
        |=> $stable({msb_flag, all_clear_flag, unsigned_wrap_bit, signed_wrap_bit}))
        else $error("flags moved without suffix");

    AST_EQUAL: assert property (@(posedge mclk) disable iff (!resetn) // see RULE_13
        clk_en && instr_valid && in_if_then_block
        && cond_code == cfe_pkg::COND_EQUAL
        |=> exec_taken == $past(all_clear_flag))
        else $error("equal test wrong");

    AST_NEGATIVE: assert property (@(posedge mclk) disable iff (!resetn) // see RULE_13
        clk_en && instr_valid && in_if_then_block
        && cond_code == cfe_pkg::COND_NEGATIVE
        |=> exec_taken == $past(msb_flag))
        else $error("negative test wrong");

    AST_OVF_CLEAR: assert property (@(posedge mclk) disable iff (!resetn) // see RULE_13
        clk_en && instr_valid && in_if_then_block
        && cond_code == cfe_pkg::COND_OVERFLOW_CLEAR
        |=> exec_taken == $past(!signed_wrap_bit))
        else $error("overflow clear test wrong");

    AST_CARRY_SET: assert property (@(posedge mclk) disable iff (!resetn) // see RULE_14
        clk_en && instr_valid && in_if_then_block
        && cond_code == cfe_pkg::COND_UNSIGNED_HIGHER_SAME
        |=> exec_taken == $past(unsigned_wrap_bit))
        else $error("carry set test wrong");

    AST_LOWER_SAME: assert property (@(posedge mclk) disable iff (!resetn) // see RULE_15
        clk_en && instr_valid && in_if_then_block
        && cond_code == cfe_pkg::COND_UNSIGNED_LOWER_SAME
        |=> exec_taken == $past(!unsigned_wrap_bit || all_clear_flag))
        else $error("lower-or-same test wrong");

    AST_SIGNED_LESS: assert property (@(posedge mclk) disable iff (!resetn) // see RULE_16
        clk_en && instr_valid && in_if_then_block
        && cond_code == cfe_pkg::COND_SIGNED_LESS
        |=> exec_taken == $past(msb_flag != signed_wrap_bit))
        else $error("signed less test wrong");

    AST_WIDE_ECHO: assert property (@(posedge mclk) disable iff (!resetn) // see RULE_19
        clk_en
        |=> result_wide == $past(instr_wide))
        else $error("encoding width not echoed");

    AST_LOGIC_KEEP: assert property (@(posedge mclk) disable iff (!resetn) // see RULE_03
        clk_en && flag_upd && is_logic && !shift_carry_valid
        |=> $stable({unsigned_wrap_bit, signed_wrap_bit}))
        else $error("logical op moved carry or overflow");

    AST_FROZEN: assert property (@(posedge mclk) disable iff (!resetn) // see RULE_03
        !clk_en
        |=> $stable({msb_flag, all_clear_flag, unsigned_wrap_bit, signed_wrap_bit, result_data,
            result_write, exec_taken, exc_raised, pc_base, result_wide, cond_misplaced}))
        else $error("state moved while frozen");

endmodule : cfe_condition_flag_evaluator

// [tb/cfe_pipe_model.sv]
`timescale 1ns/1ns

// Fetch and decode stage: one instruction per call, driven on the falling edge
module cfe_pipe_model (
    input wire logic mclk,
    output logic clk_en,
    output logic instr_valid,
    output logic [31:0] instr_addr,
    output logic instr_wide,
    output logic [3:0] cond_code,
    output logic in_if_then_block,
    output logic is_label_branch,
    output logic [2:0] op_class,
    output logic set_flags,
    output logic dest_write,
    output logic exc_request,
    output logic [31:0] operand_a,
    output logic [31:0] operand_b,
    output logic shift_carry,
    output logic shift_carry_valid,
    output logic [31:0] label_offset
);
    logic [31:0] next_addr = 32'h0000_1002;

    // Idle values; the core never stalls this stage
    initial begin
        clk_en = 1'b1;
        instr_valid = 1'b0;
        instr_wide = 1'b0;
        {instr_addr, operand_a, operand_b, label_offset} = '0;
        {cond_code, op_class} = 7'h0;
        {in_if_then_block, is_label_branch, set_flags, dest_write, exc_request} = 5'h0;
        {shift_carry, shift_carry_valid} = 2'h0;
    end

    // Present one instruction; ctl is {sf, itb, branch, dest, exc, carry valid, carry}
    task automatic issue(input logic [3:0] cc, input logic [2:0] op, input logic [6:0] ctl,
            input logic [31:0] a, input logic [31:0] b, output logic [31:0] ad);
        @(negedge mclk);
        clk_en = 1'b1;
        instr_wide = ~instr_wide;
        instr_addr = next_addr;
        next_addr = next_addr + (instr_wide ? 32'h4 : 32'h2);
        {set_flags, in_if_then_block, is_label_branch, dest_write, exc_request} = ctl[6:2];
        {shift_carry_valid, shift_carry} = ctl[1:0];
        cond_code = cc;
        op_class = op;
        operand_a = a;
        operand_b = b;
        label_offset = b;
        instr_valid = 1'b1;
        ad = instr_addr;
        @(posedge mclk);
    endtask : issue

    // One frozen cycle: a flag-setting add that must leave no trace
    task automatic hold_off();
        @(negedge mclk);
        clk_en = 1'b0;
        instr_wide = ~instr_wide;
        {cond_code, op_class} = 7'h70;
        {set_flags, dest_write, exc_request} = 3'h7;
        {operand_a, operand_b} = {32'hFFFF_FFFF, 32'h0000_0001};
        @(posedge mclk);
    endtask : hold_off
endmodule : cfe_pipe_model

// [tb/tb_top.sv]
`timescale 1ns/1ns

module tb_top;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic clk_en, instr_valid, instr_wide, in_if_then_block, is_label_branch, set_flags;
    logic dest_write, exc_request, shift_carry, shift_carry_valid;
    logic [31:0] instr_addr, operand_a, operand_b, label_offset, result_data, pc_base;
    logic [3:0] cond_code;
    logic [2:0] op_class;
    logic msb_flag, all_clear_flag, unsigned_wrap_bit, signed_wrap_bit;
    logic result_write, exec_taken, exc_raised, result_wide, cond_misplaced;
    int n_mismatch = 0;
    int checks_done = 0;
    logic n = 1'b0, z = 1'b0, c = 1'b0, v = 1'b0;
    logic [31:0] fa [5] = '{32'h7FFF_FFFF, 32'hFFFF_FFFF, 32'h0, 32'h8000_0000, 32'h5};
    logic [31:0] fb [5] = '{32'h1, 32'h1, 32'h1, 32'h8000_0000, 32'h3};
    logic [2:0] fo [5] = '{3'h0, 3'h0, 3'h1, 3'h0, 3'h1};

    // Clock at 10 MHz
    always #50 mclk = ~mclk;

    cfe_pipe_model u_pm (.mclk, .clk_en, .instr_valid, .instr_addr, .instr_wide, .cond_code,
        .in_if_then_block, .is_label_branch, .op_class, .set_flags, .dest_write,
        .exc_request, .operand_a, .operand_b, .shift_carry, .shift_carry_valid, .label_offset);

    cfe_condition_flag_evaluator uut (.mclk, .resetn, .clk_en, .instr_valid, .instr_addr,
        .instr_wide, .cond_code, .in_if_then_block, .is_label_branch, .op_class, .set_flags,
        .dest_write, .exc_request, .operand_a, .operand_b, .shift_carry, .shift_carry_valid,
        .label_offset, .msb_flag, .all_clear_flag, .unsigned_wrap_bit, .signed_wrap_bit,
        .result_data, .result_write, .exec_taken, .exc_raised, .pc_base, .result_wide,
        .cond_misplaced);

    // Expected condition outcome, indexed by code, F last
    function automatic logic cond_ok(input logic [3:0] cc);
        logic [15:0] t;
        t = {2'b11, z | (n != v), !z && (n == v), n != v, n == v, !c || z, c && !z,
            !v, v, !n, n, !c, c, !z, z};
        return t[cc];
    endfunction : cond_ok

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    // One instruction with its expected outcome
    task automatic run(input logic [3:0] cc, input logic [2:0] op, input logic [6:0] ctl,
            input logic [31:0] a, input logic [31:0] b);
        logic [32:0] s;
        logic [31:0] ad, pb, g, e;
        logic pass, bad;
        u_pm.issue(cc, op, ctl, a, b, ad);
        pb = ctl[4] ? ad + 32'h4 : (ad + 32'h4) & ~32'h2;
        bad = cc != 4'hE && !ctl[5] && !ctl[4];
        pass = cond_ok(cc) && !bad;
        case (op)
            3'h0: s = {1'b0, a} + {1'b0, b};
            3'h1: s = {1'b0, a} + {1'b0, ~b} + 33'h1;
            3'h3: s = {c, a & b};
            3'h4: s = {c, a | b};
            3'h5: s = {c, a ^ b};
            3'h6: s = {c, pb + b};
            3'h7: s = {c, a};
            default: s = {c, b};
        endcase
        if (op > 3'h1 && ctl[1]) s[32] = ctl[0];
        if (pass && ctl[6] && op < 3'h6) begin
            if (op < 3'h2) v = (a[31] == (b[31] ^ op[0])) && (s[31] != a[31]);
            n = s[31];
            z = s[31:0] == 32'h0;
            c = s[32];
        end
        #1;
        g = {27'h0, exec_taken, result_write, exc_raised, cond_misplaced, result_wide};
        e = {27'h0, pass, pass & ctl[3], pass & ctl[2], bad, u_pm.instr_wide};
        chk(g, e, "control");
        g = {28'h0, msb_flag, all_clear_flag, unsigned_wrap_bit, signed_wrap_bit};
        chk(g, {28'h0, n, z, c, v}, "flags");
        chk(pc_base, pb, "label base");
        if (pass && ctl[3]) chk(result_data, s[31:0], "result");
    endtask : run

    task automatic tally_and_finish();
        $display("checks %0d, mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : tally_and_finish

    // Main sequence: flag states times all codes, then the awkward cases
    initial begin
        repeat (16) @(posedge mclk);
        #1;
        chk({pc_base[30:0], exec_taken}, 32'h0, "reset");
        @(negedge mclk);
        resetn = 1'b1;
        for (int i = 0; i < 5; i++) begin
            run(4'hE, fo[i], 7'h48, fa[i], fb[i]);
            for (int k = 0; k < 16; k++) begin
                run(4'(k), 3'h2, 7'h2C, 32'h0, 32'hA5);
            end
        end
        run(4'h0, 3'h0, 7'h6C, 32'h1, 32'h1);
        run(4'hE, 3'h0, 7'h08, 32'h0, 32'h0);
        run(4'h1, 3'h2, 7'h4C, 32'h0, 32'h0);
        run(4'h1, 3'h7, 7'h10, 32'h0, 32'h0);
        run(4'hE, 3'h6, 7'h48, 32'h0, 32'hFFFF_FFF0);
        run(4'hE, 3'h3, 7'h48, 32'hF0, 32'h0F);
        run(4'hE, 3'h4, 7'h4B, 32'h8000_0000, 32'h0);
        u_pm.hold_off();
        #1;
        chk({28'h0, msb_flag, all_clear_flag, unsigned_wrap_bit, signed_wrap_bit},
            {28'h0, n, z, c, v}, "frozen flags");
        chk({27'h0, exec_taken, result_write, exc_raised, result_wide, cond_misplaced},
            {27'h0, 3'h6, ~u_pm.instr_wide, 1'b0}, "frozen control");
        chk(result_data, 32'h8000_0000, "frozen result");
        run(4'hE, 3'h5, 7'h4A, 32'hFF, 32'hFF);
        tally_and_finish();
    end

    // Watchdog well beyond the expected run length
    initial begin
        #200000;
        n_mismatch++;
        tally_and_finish();
    end
endmodule : tb_top
